/* include/ilpe_cfg.svh */
`ifndef ILPE_CFG_SVH
`define ILPE_CFG_SVH

// =====================================================
// port addresses
`define ILPE_ADDR_IGC       6'h38
`define ILPE_ADDR_CSC       6'h3D
// =====================================================
// field positions and masks
`define ILPE_CSC_MODE_LO    8
`define ILPE_CSC_MODE_HI    10
`define ILPE_IGC_ARM_MASK   16'h4000
`define ILPE_IGC_ARM_BIT    14
// =====================================================
// reset values
`define ILPE_IGC_RESET      16'h0000
`define ILPE_CSC_RESET      16'h0000
// =====================================================
// opcodes, timing and the deep mode encoding
`define ILPE_OP_HALT        17'h1FE20
`define ILPE_HALT_CYCLES    1
`define ILPE_MODE_DEEP      3'h4

`endif

/* include/ilpe_pkg.sv */
package ilpe_pkg;

    // =====================================================
    // run mode, or the low power mode chosen at halt
    typedef enum logic [1:0] {
        ILPE_RUN_MODE,
        ILPE_LIGHT_IDLE,
        ILPE_MID_IDLE,
        ILPE_DEEP_SLEEP
    } ilpe_pwr_e;

    typedef enum logic {
        ILPE_ST_RUN,
        ILPE_ST_HALT
    } ilpe_state_e;

    // =====================================================
    // i/o port access from the core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } ilpe_io_s;

    // =====================================================
    // decoded instruction slot from the core
    typedef struct packed {
        logic        valid;
        logic        in_repeat;
        logic [16:0] opcode;
    } ilpe_instr_s;

endpackage

/* design/ilpe_idle_ctrl.sv */
`timescale 1ns/1ps
`include "ilpe_cfg.svh"
module ilpe_idle_ctrl #(
    parameter int DATA_W      = 16,
    parameter int ADDR_W      = 6,
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire ilpe_pkg::ilpe_io_s    io,
    output logic [DATA_W-1:0]          io_rdata,
    input  wire ilpe_pkg::ilpe_instr_s instr,
    input  wire logic                  ext_irq,
    output logic                       core_clk_en,
    output logic                       pc_inc,
    output logic                       flags_hold,
    output logic                       repeat_reject,
    output ilpe_pkg::ilpe_pwr_e        pwr_mode,
    output logic [DATA_W-1:0]          igc_value,
    output logic [DATA_W-1:0]          csc_value
);
    import ilpe_pkg::*;

    // =====================================================
    // parameter limits
    // the carrier structs fix the bus at 16 data and 6 address bits
    if (DATA_W != 16 || ADDR_W != 6) begin : g_bad_width
        $error("ilpe_idle_ctrl: bus widths must match the carrier structs");
    end

    // a single flop would let a metastable level reach the state machine
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("ilpe_idle_ctrl: at least two synchroniser stages are needed");
    end

    // the halt is built as a one-cycle instruction only
    if (`ILPE_HALT_CYCLES != 1) begin : g_bad_cycles
        $error("ilpe_idle_ctrl: halt must complete in one cycle");
    end

    // =====================================================
    // registers and decode wires
    logic [DATA_W-1:0]      igc_q;
    logic [DATA_W-1:0]      csc_q;
    ilpe_state_e            state_q;
    ilpe_pwr_e              mode_q;
    logic                   pc_inc_q;
    logic                   rej_q;
    logic [DATA_W-1:0]      rdata_q;
    logic [SYNC_STAGES-1:0] irq_sync_q;
    logic                   irq_seen;
    logic                   is_halt;
    logic                   is_rpt_halt;
    logic                   igc_hit;
    logic                   csc_hit;
    logic                   run_now;

    // =====================================================
    // decoders
    // the opcode match is shared by halt entry and repeat refusal
    function automatic logic halt_op(input logic [16:0] op);
        halt_op = (op == `ILPE_OP_HALT);
    endfunction

    // shared by the write and the read decode
    function automatic logic port_hit(input logic [5:0] a, input logic [5:0] target);
        port_hit = (a == target);
    endfunction

    // only the deep encoding is fixed; other settings fall back to the two idles
    function automatic ilpe_pwr_e pick_mode(input logic [2:0] sel, input logic arm);
        if (sel == `ILPE_MODE_DEEP && arm) begin
            pick_mode = ILPE_DEEP_SLEEP;
        end else if (sel[2]) begin
            pick_mode = ILPE_MID_IDLE;
        end else begin
            pick_mode = ILPE_LIGHT_IDLE;
        end
    endfunction

    // =====================================================
    // instruction and port decode
    assign run_now     = (state_q == ILPE_ST_RUN);
    assign is_halt     = instr.valid && halt_op(instr.opcode) && !instr.in_repeat;
    assign is_rpt_halt = instr.valid && halt_op(instr.opcode) && instr.in_repeat;
    assign igc_hit     = port_hit(io.addr, `ILPE_ADDR_IGC);
    assign csc_hit     = port_hit(io.addr, `ILPE_ADDR_CSC);

    // =====================================================
    // interrupt pin synchroniser
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_sync_q[0] <= 1'b0;
        end else begin
            irq_sync_q[0] <= ext_irq;
        end
    end

    for (genvar g = 1; g < SYNC_STAGES; g++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!nrst) begin
                irq_sync_q[g] <= 1'b0;
            end else begin
                irq_sync_q[g] <= irq_sync_q[g-1];
            end
        end
    end

    // only the last stage feeds logic
    assign irq_seen = irq_sync_q[SYNC_STAGES-1];

    // =====================================================
    // port registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            igc_q <= `ILPE_IGC_RESET;
        end else if (io.wr && igc_hit) begin
            igc_q <= io.wdata;
        end
    end

    // all bits kept; the pll multiplier field is not interpreted here
    always_ff @(posedge clk) begin
        if (!nrst) begin
            csc_q <= `ILPE_CSC_RESET;
        end else if (io.wr && csc_hit) begin
            csc_q <= io.wdata;
        end
    end

    // write-only register reads as zero so stale settings never leak
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (io.rd && igc_hit) begin
            rdata_q <= igc_q;
        end else if (io.rd && csc_hit) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
        end
    end

    // =====================================================
    // halt state machine
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ILPE_ST_RUN;
        end else begin
            case (state_q)
                ILPE_ST_RUN: begin
                    if (is_halt) begin
                        state_q <= ILPE_ST_HALT;
                    end
                end
                ILPE_ST_HALT: begin
                    if (irq_seen) begin
                        state_q <= ILPE_ST_RUN;
                    end
                end
                default: begin
                    state_q <= ILPE_ST_RUN;
                end
            endcase
        end
    end

    // mode latched at entry so later port writes cannot alter a sleep in progress
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q <= ILPE_RUN_MODE;
        end else if (run_now && is_halt) begin
            mode_q <= pick_mode(csc_q[`ILPE_CSC_MODE_HI:`ILPE_CSC_MODE_LO],
                                igc_q[`ILPE_IGC_ARM_BIT]);
        end else if (!run_now && irq_seen) begin
            mode_q <= ILPE_RUN_MODE;
        end
    end

    // =====================================================
    // single-cycle pc step
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pc_inc_q <= 1'b0;
        end else begin
            pc_inc_q <= run_now && is_halt;
        end
    end

    // a repeated halt is dropped, never stretched over the repeat count
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rej_q <= 1'b0;
        end else begin
            rej_q <= is_rpt_halt;
        end
    end

    // =====================================================
    // outputs
    // clock enable is a state bit, so the gate sees no glitch
    assign core_clk_en   = run_now;
    assign flags_hold    = run_now && is_halt;
    assign pc_inc        = pc_inc_q;
    assign repeat_reject = rej_q;
    assign pwr_mode      = mode_q;
    assign io_rdata      = rdata_q;
    assign igc_value     = igc_q;
    assign csc_value     = csc_q;

endmodule

/* verif/ilpe_idle_ctrl_chk.sv */
`timescale 1ns/1ps
`include "ilpe_cfg.svh"
module ilpe_idle_ctrl_chk (
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire ilpe_pkg::ilpe_io_s    io,
    input wire logic [15:0]           io_rdata,
    input wire ilpe_pkg::ilpe_instr_s instr,
    input wire logic                  ext_irq,
    input wire logic                  core_clk_en,
    input wire logic                  pc_inc,
    input wire logic                  flags_hold,
    input wire logic                  repeat_reject,
    input wire ilpe_pkg::ilpe_pwr_e   pwr_mode,
    input wire logic [15:0]           igc_value,
    input wire logic [15:0]           csc_value
);
    import ilpe_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // =====================================================
    // halt seen while running
    logic hlt, go, deep;
    assign hlt  = instr.valid && instr.opcode == `ILPE_OP_HALT && core_clk_en;
    assign go   = hlt && !instr.in_repeat;
    assign deep = csc_value[10:8] == 3'h4 && igc_value[14];
    halt_stop_a: assert property (go |=> !core_clk_en && pc_inc) else $error("halt did not stop");
    irq_wake_a: assert property (!core_clk_en && ext_irq |-> ##[1:4] core_clk_en) else $error("no wake");
    only_halt_a: assert property ($fell(core_clk_en) |-> $past(go)) else $error("stop without halt");
    mode_pick_a: assert property (go && !deep |=> pwr_mode inside {ILPE_LIGHT_IDLE, ILPE_MID_IDLE})
        else $error("bad mode");
    deep_mode_a: assert property (go && deep |=> pwr_mode == ILPE_DEEP_SLEEP) else $error("no deep");
    csc_wo_a: assert property (io.rd && io.addr == 6'h3D |=> io_rdata == 16'h0000) else $error("csc read");
    igc_rd_a: assert property (io.rd && io.addr == 6'h38 |=> io_rdata == $past(igc_value))
        else $error("igc read");
    flag_keep_a: assert property (go |-> flags_hold) else $error("flags not held");
    rpt_refuse_a: assert property (hlt && instr.in_repeat |=> repeat_reject && core_clk_en)
        else $error("repeat halt");
endmodule

/* verif/test_idle_low_power_entry.sv */
`timescale 1ns/1ps
`include "ilpe_cfg.svh"
module test_idle_low_power_entry;
    import ilpe_pkg::*;
    logic        clk = 0, nrst = 0, ext_irq = 0;
    ilpe_io_s    io = '0;
    ilpe_instr_s instr = '0;
    logic [15:0] io_rdata, igc_value, csc_value;
    logic        core_clk_en, pc_inc, flags_hold, repeat_reject;
    ilpe_pwr_e   pwr_mode;
    int          miscompares = 0, total_checks = 0, cyc = 0;
    // rows: clock speed, interrupt control, expected mode; pll bits in row 1
    logic [15:0] tv[4][3] = '{'{16'h0400, 16'h4000, 16'h3}, '{16'h04FF, 16'h4000, 16'h3},
                              '{16'h0400, 16'h0000, 16'h2}, '{16'h0000, 16'h4000, 16'h1}};
    ilpe_idle_ctrl ilpe_idle_ctrl_i (.clk, .nrst, .io, .io_rdata, .instr, .ext_irq, .core_clk_en, .pc_inc,
        .flags_hold, .repeat_reject, .pwr_mode, .igc_value, .csc_value);
    initial forever #20 clk = ~clk;
    // =====================================================
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            test_done;
        end
    end
    task test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        io = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #1;
    endtask
    task rd(input logic [5:0] a, input logic [15:0] e);
        io = '{1'b0, 1'b1, a, 16'h0000};
        instr = '0;
        @(posedge clk);
        #1 chk(io_rdata, e);
    endtask
    task halt(input logic r, input logic [16:0] op);
        io = '0;
        instr = '{1'b1, r, op};
        #1 chk({15'h0, flags_hold}, {15'h0, ~r && op == `ILPE_OP_HALT});
        @(posedge clk);
        #1;
    endtask
    // irq held until the core runs again, bounded wait
    task wake;
        int k;
        k = 0;
        instr = '0;
        ext_irq = 1;
        while (k < 6 && core_clk_en !== 1'b1) begin
            @(posedge clk);
            #1 k++;
        end
        ext_irq = 0;
        chk({13'h0, core_clk_en, pwr_mode}, 16'h4);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 nrst = 1;
        chk({igc_value | csc_value}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(6'h3D, tv[i][0]);
            wr(6'h38, tv[i][1]);
            rd(6'h38, tv[i][1]);
            rd(6'h3D, 16'h0000);
            halt(1'b0, `ILPE_OP_HALT);
            chk({12'h0, core_clk_en, pc_inc, pwr_mode}, {14'h1, tv[i][2][1:0]});
            wake;
        end
        halt(1'b1, `ILPE_OP_HALT);
        chk({14'h0, repeat_reject, core_clk_en}, 16'h3);
        halt(1'b0, 17'h1FE90);
        chk({15'h0, core_clk_en}, 16'h1);
        rd(6'h00, 16'h0000);
        test_done;
    end
endmodule
bind ilpe_idle_ctrl ilpe_idle_ctrl_chk ilpe_idle_ctrl_chk_i (.clk, .nrst, .io, .io_rdata, .instr, .ext_irq,
    .core_clk_en, .pc_inc, .flags_hold, .repeat_reject, .pwr_mode, .igc_value, .csc_value);
